// [src/rss_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

`define RSS_ADDR_W          4
`define RSS_OFF_TRIM        4'h0
`define RSS_OFF_SICS        4'h1
`define RSS_OFF_CFG         4'h2
`define RSS_TRIM_RESET      8'hff
`define RSS_TRIM_MID        8'h80
`define RSS_BIT_IRQ_EN      0
`define RSS_BIT_WARN        1
`define RSS_BIT_LVD_CAUSE   2
`define RSS_BIT_LOCK        3
`define RSS_BIT_WDG_CAUSE   4
`define RSS_DLY_SHORT       13'd256
`define RSS_DLY_LONG        13'd4096
`define RSS_FETCH_CYC       2'd2
`define RSS_WDG_PULSE_CYC   13'd64
`define RSS_VEC_ADDR        16'hfffe

`endif

// [src/rss_pkg.sv]
// Types for the reset sequencer and supply-integrity block
package rss_pkg;
    typedef enum logic [1:0] {
        RSS_ST_ACTIVE,
        RSS_ST_DELAY,
        RSS_ST_PLL,
        RSS_ST_FETCH
    } rss_state_t;

    typedef enum logic [1:0] {
        RSS_CLK_RC,
        RSS_CLK_EXT,
        RSS_CLK_XTAL
    } rss_clksrc_t;

    typedef enum logic [1:0] {
        RSS_LVL_LOW,
        RSS_LVL_MED,
        RSS_LVL_HIGH
    } rss_level_t;

    // Option configuration that travels together
    typedef struct packed {
        rss_clksrc_t clk_src;
        logic        pll_en;
        logic        lvd_en;
        rss_level_t  lvd_level;
    } rss_cfg_t;

    // Control and status bits of the supply-integrity register
    typedef struct packed {
        logic wdg_cause;
        logic lock;
        logic lvd_cause;
        logic warn;
        logic irq_en;
    } rss_sics_t;
endpackage

// [src/rss_top.sv]
// Reset sequencer, supply-integrity register and RC trim register
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.svh"

module rss_top
    import rss_pkg::*;
(
    input  wire logic                   CLK,          // CPU clock, 250 MHz
    input  wire logic                   RSTN,         // Async reset, active low
    input  wire rss_cfg_t               CFG,          // Option configuration
    input  wire logic                   RST_PIN_I,    // Reset pin level
    output logic                        RST_PIN_O,    // Reset pin output value (0)
    output logic                        RST_PIN_OE_N, // Low while pulling pin low
    input  wire logic                   LVD_FAULT,    // Low-supply comparator
    input  wire logic                   AVD_CMP,      // Aux supply comparator
    input  wire logic                   PLL_LOCKED,   // PLL lock indication
    input  wire logic                   WDG_UNDERFLOW,// Watchdog underflow pulse
    input  wire logic                   ILLEGAL_OP,   // Illegal opcode/prefix pulse
    input  wire logic                   CPU_IMASK,    // Core interrupt mask bit
    input  wire logic                   CPU_WAIT,     // Core in WAIT mode
    input  wire logic                   CPU_HALT,     // Core in HALT mode
    input  wire logic                   IRQ_ACK,      // Warning ISR entry pulse
    input  wire logic [`RSS_ADDR_W-1:0] ADDR,         // Register address
    input  wire logic [7:0]             WDATA,        // Write data
    input  wire logic                   WR,           // Write strobe
    input  wire logic                   RD,           // Read strobe
    output logic      [7:0]             RDATA,        // Read data, next cycle
    output logic                        CORE_RESET,   // Core held in reset
    output logic                        VEC_FETCH,    // Vector fetch cycle
    output logic      [15:0]            VEC_ADDR,     // Vector byte address
    output logic                        WARN_IRQ,     // Warning interrupt request
    output logic                        WAKE_WAIT,    // Wake from WAIT
    output logic      [7:0]             RC_TRIM       // Oscillator trim code
);

    // Pin and comparator synchronisers
    logic [1:0] pin_s_q, lvd_s_q, avd_s_q, lock_s_q;
    logic       pin_low, lvd_flt, avd_lvl, lock_lvl;
    // pin caught asynchronously, so a reset enters even while halted
    logic       pin_seen_q;
    // Sequencer
    rss_state_t st_q, st_d;
    logic [12:0] cnt_q, cnt_d;
    logic [12:0] wdg_cnt_q;
    logic       wdg_hold;
    logic       src_act;
    logic [12:0] dly_len;
    // Registers
    logic [7:0] trim_q;
    rss_sics_t  sics_q;
    logic       pend_q;
    logic [7:0] rdata_q;
    logic       wr_trim, wr_sics, rd_sics, frozen;
    logic       wdg_rst, lvd_rst;
    logic       warn_live;
    // Second fetch cycle marker and warning edge history
    logic       fetch2_q;
    logic       avd_d_q;
    // Own pin drive and its recent history, to mask our own low level
    logic       own_drv;
    logic       drv_st;
    logic [2:0] drv_hist_q;

    // External pin low latched without the clock
    always_ff @(posedge CLK or negedge RST_PIN_I or negedge RSTN) begin
        if (!RSTN)
            pin_seen_q <= 1'b1;
        else if (!RST_PIN_I)
            pin_seen_q <= 1'b1;
        else
            pin_seen_q <= 1'b0;
    end

    // Two-flop synchronisers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_s_q  <= 2'b11;
            lvd_s_q  <= 2'b00;
            avd_s_q  <= 2'b00;
            lock_s_q <= 2'b00;
        end else begin
            pin_s_q  <= {pin_s_q[0], pin_seen_q};
            lvd_s_q  <= {lvd_s_q[0], LVD_FAULT};
            avd_s_q  <= {avd_s_q[0], AVD_CMP};
            lock_s_q <= {lock_s_q[0], PLL_LOCKED};
        end
    end

    // Open-drain pin reads back our own pull; only an external low counts
    assign drv_st   = (st_q == RSS_ST_ACTIVE) || (st_q == RSS_ST_DELAY);
    assign pin_low  = pin_s_q[1] & !drv_st & (drv_hist_q == 3'b000);

    // Drive history covers the pin synchroniser latency after release
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            drv_hist_q <= 3'b111;
        else
            drv_hist_q <= {drv_hist_q[1:0], own_drv};
    end
    assign lvd_flt  = lvd_s_q[1] & CFG.lvd_en;
    assign avd_lvl  = avd_s_q[1];
    assign lock_lvl = lock_s_q[1];

    // Reset source merge
    assign wdg_rst  = WDG_UNDERFLOW | ILLEGAL_OP;
    assign lvd_rst  = lvd_flt;
    assign wdg_hold = (wdg_cnt_q != 13'd0);
    assign src_act  = pin_low | lvd_flt | wdg_hold | wdg_rst;

    // Watchdog output pulse timer
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            wdg_cnt_q <= 13'd0;
        else if (wdg_rst)
            wdg_cnt_q <= `RSS_WDG_PULSE_CYC;
        else if (wdg_hold)
            wdg_cnt_q <= wdg_cnt_q - 13'd1;
    end

    // Delay length by clock source
    assign dly_len = (CFG.clk_src == RSS_CLK_XTAL) ? `RSS_DLY_LONG : `RSS_DLY_SHORT;

    // Sequencer next state
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        if (src_act) begin
            st_d  = RSS_ST_ACTIVE;
            cnt_d = 13'd0;
        end else begin
            unique case (st_q)
                RSS_ST_ACTIVE: begin
                    st_d  = RSS_ST_DELAY;
                    cnt_d = dly_len - 13'd1;
                end
                RSS_ST_DELAY: begin
                    if (cnt_q == 13'd0) begin
                        st_d = CFG.pll_en ? RSS_ST_PLL : RSS_ST_FETCH;
                        cnt_d = 13'(`RSS_FETCH_CYC) - 13'd1;
                    end else begin
                        cnt_d = cnt_q - 13'd1;
                    end
                end
                RSS_ST_PLL: begin
                    if (lock_lvl)
                        st_d = RSS_ST_FETCH;
                end
                RSS_ST_FETCH: begin
                    if (cnt_q != 13'd0)
                        cnt_d = cnt_q - 13'd1;
                end
            endcase
        end
    end

    // Sequencer state
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q  <= RSS_ST_ACTIVE;
            cnt_q <= 13'd0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Pin driven low during active and delay phases
    assign RST_PIN_O    = 1'b0;
    assign own_drv      = src_act || drv_st;
    assign RST_PIN_OE_N = !own_drv;

    // Core outputs; core held through both fetch cycles; oscillator never gated here
    assign CORE_RESET = (st_q != RSS_ST_FETCH) || (cnt_q != 13'd0) || fetch2_q || src_act;
    assign VEC_FETCH  = (st_q == RSS_ST_FETCH) && !src_act && (cnt_q != 13'd0 || fetch2_q);
    assign VEC_ADDR   = `RSS_VEC_ADDR | {15'd0, (cnt_q == 13'd0)};

    // Second fetch cycle marker
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            fetch2_q <= 1'b0;
        else
            fetch2_q <= (st_q == RSS_ST_FETCH) && (cnt_q != 13'd0) && !src_act;
    end

    // Register decode
    assign frozen    = CPU_HALT;
    assign wr_trim   = WR && ADDR == `RSS_OFF_TRIM;
    assign wr_sics   = WR && ADDR == `RSS_OFF_SICS && !frozen;
    assign rd_sics   = RD && ADDR == `RSS_OFF_SICS && !frozen;
    assign warn_live = avd_lvl & CFG.lvd_en;

    // Trim register, reset to slowest code
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            trim_q <= `RSS_TRIM_RESET;
        else if (wr_trim)
            trim_q <= WDATA;
    end
    assign RC_TRIM = trim_q;

    // Supply-integrity control/status bits
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sics_q <= '0;
        end else begin
            if (wr_sics)
                sics_q.irq_en <= WDATA[`RSS_BIT_IRQ_EN];
            if (!frozen)
                sics_q.lock <= lock_lvl;
            // Set wins over clear
            if (wdg_rst)
                sics_q.wdg_cause <= 1'b1;
            else if (lvd_rst || (wr_sics && !WDATA[`RSS_BIT_WDG_CAUSE]))
                sics_q.wdg_cause <= 1'b0;
            // Read clears; set wins
            if (lvd_rst)
                sics_q.lvd_cause <= 1'b1;
            else if (rd_sics)
                sics_q.lvd_cause <= 1'b0;
        end
    end

    // Pending warning; cleared on service entry
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            pend_q <= 1'b0;
        else if (warn_live && !avd_d_q && CFG.lvd_en)
            pend_q <= 1'b1;
        else if (IRQ_ACK)
            pend_q <= 1'b0;
    end

    // Rising-edge detector on the live warning
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            avd_d_q <= 1'b0;
        else
            avd_d_q <= warn_live;
    end

    // Interrupt and wake
    assign WARN_IRQ  = pend_q && sics_q.irq_en && CFG.lvd_en && !CPU_IMASK && !CORE_RESET;
    assign WAKE_WAIT = pend_q && sics_q.irq_en && CFG.lvd_en && CPU_WAIT;

    // Read data, one cycle later
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            rdata_q <= 8'h00;
        else if (RD && ADDR == `RSS_OFF_TRIM)
            rdata_q <= trim_q;
        else if (RD && ADDR == `RSS_OFF_SICS)
            rdata_q <= {3'h0, sics_q.wdg_cause, sics_q.lock, sics_q.lvd_cause, warn_live, sics_q.irq_en};
        else
            rdata_q <= 8'h00;
    end
    assign RDATA = rdata_q;

    // Assertions
    a_pin_low_delay: assert property (@(posedge CLK) disable iff (!RSTN)
        st_q == RSS_ST_DELAY |-> !RST_PIN_OE_N) else $error("pin released in delay");
    a_fetch_two: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(VEC_FETCH) |=> VEC_FETCH ##1 !VEC_FETCH) else $error("fetch not two cycles");
    a_vec_addr: assert property (@(posedge CLK) disable iff (!RSTN)
        VEC_FETCH |-> VEC_ADDR[15:1] == 15'h7fff) else $error("bad vector");
    a_delay_restart: assert property (@(posedge CLK) disable iff (!RSTN)
        src_act |=> st_q == RSS_ST_ACTIVE) else $error("delay not restarted");
    a_warn_gate: assert property (@(posedge CLK) disable iff (!RSTN)
        !CFG.lvd_en |-> !WARN_IRQ) else $error("warning without detector");
    a_irq_mask: assert property (@(posedge CLK) disable iff (!RSTN)
        CPU_IMASK |-> !WARN_IRQ) else $error("irq while masked");
    a_wdg_cause: assert property (@(posedge CLK) disable iff (!RSTN)
        wdg_rst |=> sics_q.wdg_cause) else $error("watchdog cause not set");
    a_lvd_hold: assert property (@(posedge CLK) disable iff (!RSTN)
        lvd_flt |-> !RST_PIN_OE_N) else $error("pin not held in fault");
    a_trim_rst: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(RSTN) |-> trim_q == `RSS_TRIM_RESET) else $error("trim reset value");

endmodule
`default_nettype wire

// [testbench/rss_pin_model.sv]
// Board-side model of the open-drain reset pin and its pull-up
`timescale 1ns/1ps
`default_nettype none

module rss_pin_model (
    input  wire logic dev_oe_n, // Device pulls the pin when low
    input  wire logic ext_low,  // Board circuit pulls the pin
    output logic      pin       // Resolved pin level
);
    // Any puller wins, otherwise the pull-up sets the level
    assign pin = (dev_oe_n === 1'b0 || ext_low === 1'b1) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// [testbench/tb_rss_top.sv]
// Self-checking bench for the reset sequencer and supply-integrity block
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.svh"

module tb_rss_top
    import rss_pkg::*;
;
    logic        clk, rstn, pin, pin_o, pin_oe_n, ext_low, low_supply_detector, aux_supply_detector, lock;
    logic        wdg, ill, imask, cwait, chalt, ack, wr, rd;
    logic        core_rst, vfetch, wirq, wake;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, trim, d;
    logic [15:0] vaddr;
    rss_cfg_t    cfg;
    int          miscompares, comparisons;

    rss_top rss_top_i (.CLK(clk), .RSTN(rstn), .CFG(cfg), .RST_PIN_I(pin), .RST_PIN_O(pin_o),
        .RST_PIN_OE_N(pin_oe_n), .LVD_FAULT(low_supply_detector), .AVD_CMP(aux_supply_detector), .PLL_LOCKED(lock),
        .WDG_UNDERFLOW(wdg), .ILLEGAL_OP(ill), .CPU_IMASK(imask), .CPU_WAIT(cwait),
        .CPU_HALT(chalt), .IRQ_ACK(ack), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CORE_RESET(core_rst), .VEC_FETCH(vfetch), .VEC_ADDR(vaddr),
        .WARN_IRQ(wirq), .WAKE_WAIT(wake), .RC_TRIM(trim));
    rss_pin_model rss_pin_model_i (.dev_oe_n(pin_oe_n), .ext_low(ext_low), .pin(pin));

    // Clock generator
    always #2 clk = ~clk;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Pulse one same-clock input for a single cycle: 0 watchdog, 1 illegal op, 2 ack
    task automatic pulse(input int which);
        @(posedge clk);
        if (which == 0)
            wdg <= 1'b1;
        else if (which == 1)
            ill <= 1'b1;
        else
            ack <= 1'b1;
        @(posedge clk);
        {wdg, ill, ack} <= 3'b000;
        repeat (4) @(posedge clk);
    endtask

    // Follow a running sequence to its end; pin-low cycles and fetched addresses
    task automatic seq(input int dly, input int slack);
        int lowc;
        int n;
        logic [15:0] va[$];
        lowc = 0;
        for (n = 0; n < 12000 && core_rst !== 1'b0; n++) begin
            @(posedge clk);
            #1;
            if (pin === 1'b0) lowc++;
            if (vfetch === 1'b1) va.push_back(vaddr);
        end
        chk(16'(lowc >= dly && lowc <= dly + slack), 16'h1);
        chk(16'(va.size()), 16'h2);
        chk(va[0], `RSS_VEC_ADDR);
        chk(va[1], `RSS_VEC_ADDR + 16'h1);
    endtask

    task automatic t_por();
        seq(256, 16);
        chk(16'(pin_o), 16'h0);
        rreg(`RSS_OFF_TRIM, d);
        chk(16'(d), 16'(`RSS_TRIM_RESET));
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d), 16'h0);
        $display("test power-on done");
    endtask

    task automatic t_trim();
        wreg(`RSS_OFF_TRIM, `RSS_TRIM_MID);
        rreg(`RSS_OFF_TRIM, d);
        chk(16'(d), 16'h80);
        wreg(`RSS_OFF_TRIM, 8'h00);
        #1;
        chk(16'(trim), 16'h0);
        rreg(4'hf, d);
        chk(16'(d), 16'h0);
        $display("test trim done");
    endtask

    task automatic t_wdg();
        cfg.clk_src <= RSS_CLK_XTAL;
        pulse(0);
        chk(16'(core_rst), 16'h1);
        seq(4096, 80);
        cfg.clk_src <= RSS_CLK_EXT;
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h14), 16'h10);
        wreg(`RSS_OFF_SICS, 8'h00);
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h10), 16'h0);
        pulse(1);
        chk(16'(core_rst), 16'h1);
        seq(256, 80);
        $display("test watchdog done");
    endtask

    task automatic t_lvd();
        low_supply_detector <= 1'b1;
        repeat (30) @(posedge clk);
        chk(16'(pin), 16'h0);
        low_supply_detector <= 1'b0;
        repeat (2) @(posedge clk);
        seq(256, 16);
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h14), 16'h04);
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h04), 16'h0);
        ext_low <= 1'b1;
        fork
            begin
                repeat (10) @(posedge clk);
                chk(16'(core_rst), 16'h1);
                ext_low <= 1'b0;
            end
        join_none
        repeat (3) @(posedge clk);
        seq(256, 16);
        $display("test low supply done");
    endtask

    task automatic t_warn();
        wreg(`RSS_OFF_SICS, 8'h01);
        aux_supply_detector <= 1'b1;
        repeat (6) @(posedge clk);
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h03), 16'h03);
        chk(16'(wirq), 16'h1);
        imask <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(wirq), 16'h0);
        imask <= 1'b0;
        cwait <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(wake), 16'h1);
        pulse(2);
        chk(16'(wirq), 16'h0);
        cwait <= 1'b0;
        chalt <= 1'b1;
        wreg(`RSS_OFF_SICS, 8'h00);
        chalt <= 1'b0;
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h01), 16'h01);
        aux_supply_detector <= 1'b0;
        cfg.lvd_en <= 1'b0;
        repeat (4) @(posedge clk);
        aux_supply_detector <= 1'b1;
        repeat (6) @(posedge clk);
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h02), 16'h0);
        chk(16'(wirq), 16'h0);
        $display("test warning done");
    endtask

    task automatic t_pll();
        cfg.pll_en <= 1'b1;
        pulse(0);
        repeat (400) @(posedge clk);
        chk(16'(core_rst), 16'h1);
        lock <= 1'b1;
        seq(0, 0);
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h08), 16'h08);
        lock <= 1'b0;
        repeat (4) @(posedge clk);
        rreg(`RSS_OFF_SICS, d);
        chk(16'(d & 8'h08), 16'h0);
        $display("test pll done");
    endtask

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        cfg = '{clk_src: RSS_CLK_RC, pll_en: 1'b0, lvd_en: 1'b1, lvd_level: RSS_LVL_MED};
        {ext_low, low_supply_detector, aux_supply_detector, lock, wdg, ill, imask, cwait, chalt, ack, wr, rd} = '0;
        addr = '0;
        wdata = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_por();
        t_trim();
        t_wdg();
        t_lvd();
        t_warn();
        t_pll();
        conclude();
    end

    // Watchdog against a hang
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule

`default_nettype wire
